/* sim/spi_far_slave.sv */
// Far serial slave: mode 0, MSB first, frame length set by nbits.
// Assumes select and clock are resolved wires from the bench.
`timescale 1ns/1ps
module spi_far_slave (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic [4:0] nbits,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] got
);
  logic [15:0] sh;
  initial begin
    miso = 1'b0;
    got = 16'h0000;
  end
  // Same length both sides: reply MSB aligned on select
  always @(negedge sel_n) begin
    sh = reply << (5'h10 - nbits);
    miso = sh[15];
    got = 16'h0000;
  end
  always @(posedge sck) begin
    if (!sel_n) got = {got[14:0], mosi};
  end
  // Shift out on fall, mode 0
  always @(negedge sck) begin
    if (!sel_n) begin
      sh = sh << 1;
      miso = sh[15];
    end
  end
  // Released line: show the inverse, never a stale bit
  always @(posedge sel_n) begin
    miso = ~miso;
  end
endmodule

/* sim/synchronous_serial_port_tb.sv */
// Bench for the serial port: register tasks, master frames, queue
// limits and audio framing rates.
// Assumes a far slave model on the pins and the design's constants.
`timescale 1ns/1ps
`include "ssp_params.svh"
module synchronous_serial_port_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic sck_o, sck_oe_n, ws_o, ws_oe_n, dout_o, dout_oe_n, mck_o;
  logic miso;
  logic [4:0] nb = 5'h08;
  logic [15:0] rep = 16'h0000;
  logic [15:0] got;
  // Far master pins for the slave scenario; slv routes din to the bench
  logic sck_m = 1'b0;
  logic ws_m = 1'b1;
  logic din_m = 1'b0;
  logic slv = 1'b0;
  logic [7:0] rx_pat = 8'h5c;
  logic sck_l = 1'b0;
  logic ws_l = 1'b1;
  logic mck_l = 1'b0;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0, t_s = 0, per = 0, t_w = 0, ws_per = 0;
  int mck_n = 0, mck_at = 0, mck_per = 0;
  // Resolved pins: clock pulled low, select pulled high when released
  wire logic sck_w = sck_oe_n ? 1'b0 : sck_o;
  wire logic sel_w = ws_oe_n ? 1'b1 : ws_o;
  // Released data line shows the inverse, never a stale bit
  wire logic mosi_w = dout_oe_n ? ~dout_o : dout_o;
  wire logic din_w = slv ? din_m : miso;

  synchronous_serial_port i_synchronous_serial_port (
    .clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sck_i(sck_m), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .ws_i(ws_m), .ws_o(ws_o), .ws_oe_n(ws_oe_n),
    .din_i(din_w), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .mck_o(mck_o)
  );
  spi_far_slave i_spi_far_slave (
    .sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .nbits(nb),
    .reply(rep), .miso(miso), .got(got)
  );

  // Clock at 100 ns
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Edge monitor: clock period, word-select period, mck per frame
  always @(posedge clk_sys) begin
    if (sck_o & ~sck_l) begin
      per = cyc - t_s;
      t_s = cyc;
    end
    if (mck_o & ~mck_l) mck_n++;
    if (ws_o & ~ws_l) begin
      ws_per = cyc - t_w;
      t_w = cyc;
      mck_per = mck_n - mck_at;
      mck_at = mck_n;
    end
    {sck_l, ws_l, mck_l} = {sck_o, ws_o, mck_o};
    cyc++;
  end

  task end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    chk(nm, e, d);
  endtask
  // Poll one status bit, bounded
  task wait_bit(input int b, input logic v);
    logic [31:0] d;
    d = 32'h0000_0000;
    for (int i = 0; i < 3000; i++) begin
      rd_reg(`A_STAT, d);
      if (d[b] === v) break;
    end
    chk("status wait", {31'h0, v}, {31'h0, d[b]});
  endtask
  // One master frame, full duplex
  task spi_xfer(input logic [2:0] br, input logic [3:0] fl,
                input logic [15:0] tx, input logic [15:0] r);
    logic [31:0] m;
    m = (32'h1 << (32'(fl) + 1)) - 1;
    nb <= 5'(fl) + 5'h01;
    rep <= r;
    wr_reg(`A_DATA, {16'h0000, tx});
    wr_reg(`A_CTRL, 32'h0000_001b | 32'(br) << 5 | 32'(fl) << 8);
    wait_bit(`S_RXFULL, 1'b1);
    chk("sck drive", 32'h0, {31'h0, sck_oe_n});
    rd_chk("rx word", `A_DATA, 32'(r) & m);
    chk("far got", 32'(tx) & m, 32'(got) & m);
    chk("sck period", 32'h2 << br, 32'(per));
    wr_reg(`A_CTRL, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [7:0] g;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk("ctrl rst", `A_CTRL, `CTRL_RST);
    rd_chk("div rst", `A_DIV, 32'(`DIV_RST));
    rd_chk("stat rst", `A_STAT, 32'h0000_0004);
    // Read data stand one cycle only, then fall back to zero
    @(posedge clk_sys);
    #1 chk("rdata idle", 32'h0, rdata);
    chk("sck oe rst", 32'h1, {31'h0, sck_oe_n});
    wr_reg(4'h2, 32'hffff_ffff);
    rd_chk("unmapped", 4'h2, 32'h0000_0000);
    rd_chk("ctrl kept", `A_CTRL, 32'h0000_0000);
    spi_xfer(3'h2, 4'h3, 16'h000a, 16'h0005);
    spi_xfer(3'h2, 4'hf, 16'hc3a5, 16'h5a3c);
    for (int i = 2; i < 8; i++) spi_xfer(3'(i), 4'h7, 16'h0096, 16'h0069);
    // Two frames unread: second word overruns the first
    wr_reg(`A_DATA, 32'h0000_0011);
    wr_reg(`A_DATA, 32'h0000_0022);
    wr_reg(`A_CTRL, 32'h0000_025b);
    wait_bit(`S_OVR, 1'b1);
    wr_reg(`A_CTRL, 32'h0000_0000);
    wr_reg(`A_STAT, 32'h0000_0010);
    rd_reg(`A_DATA, d);
    rd_chk("ovr clear", `A_STAT, 32'h0000_0004);
    // Queue fills to 32 words, then refuses
    for (int i = 0; i < 32; i++) wr_reg(`A_DATA, 32'(i));
    rd_chk("q full", `A_STAT, 32'h0000_0002);
    wr_reg(`A_DATA, 32'h0000_00ff);
    rd_chk("q drop", `A_STAT, 32'h0000_0022);
    wr_reg(`A_STAT, 32'h0000_0020);
    rd_chk("drop clear", `A_STAT, 32'h0000_0002);
    // Audio master: every standard, both slot widths, two dividers
    for (int i = 0; i < 8; i++) begin
      wr_reg(`A_DIV, 32'h0000_0002 + 32'(i[0]) * 2);
      wr_reg(`A_CTRL, 32'h0002_000f | 32'(i >> 1) << 12 |
             32'(i[0]) << 14 | 32'(i[0]) << 16);
      repeat (5000) @(posedge clk_sys);
      chk("ws period", 32'd512 * (2 + 32'(i[0]) * 2), 32'(ws_per));
      chk("mck per frame", 32'd256, 32'(mck_per));
      chk("dout drive", 32'h0, {31'h0, dout_oe_n});
      chk("ws drive", 32'h0, {31'h0, ws_oe_n});
      wr_reg(`A_CTRL, 32'h0000_0000);
    end
    rd_reg(`A_STAT, d);
    chk("q drained", 32'h1, {31'h0, d[`S_TXEMPTY]});
    // Slave frame: bench plays the far master, 8 bits, mode 0
    slv <= 1'b1;
    wr_reg(`A_DATA, 32'h0000_00b4);
    wr_reg(`A_CTRL, 32'h0000_0719);
    ws_m <= 1'b0;
    g = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      din_m <= rx_pat[i];
      repeat (8) @(posedge clk_sys);
      sck_m <= 1'b1;
      #1 g = {g[6:0], dout_o};
      repeat (8) @(posedge clk_sys);
      sck_m <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    ws_m <= 1'b1;
    chk("slave out", 32'h0000_00b4, {24'h0, g});
    rd_chk("slave in", `A_DATA, 32'h0000_005c);
    wr_reg(`A_CTRL, 32'h0000_0000);
    slv <= 1'b0;
    end_sim;
  end
  // Watchdog well beyond the expected run
  initial begin
    #8_000_000;
    failures++;
    end_sim;
  end
endmodule

/* src/ssp_params.svh */
// Constants of the synchronous serial port: register map, field
// positions, reset values and clock ratios.
// Included by the design file; holds definitions only.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// Register byte offsets
`define A_CTRL 4'h0
`define A_DIV 4'h4
`define A_DATA 4'h8
`define A_STAT 4'hc
// Control register fields
`define F_EN 0
`define F_MST 1
`define F_AUD 2
`define F_TXEN 3
`define F_RXEN 4
`define F_BR 7:5
`define F_FLEN 11:8
`define F_STD 13:12
`define F_DLEN 15:14
`define F_CH32 16
`define F_MCKEN 17
// Status register fields
`define S_BUSY 0
`define S_TXFULL 1
`define S_TXEMPTY 2
`define S_RXFULL 3
`define S_OVR 4
`define S_DROP 5
`define S_CHAN 6
// Reset values
`define CTRL_RST 32'h0000_0000
`define DIV_RST 8'h02
// Frame and slot lengths in bits (frame field holds length - 1)
`define FLEN_MIN 4'h3
`define SLOT16 6'h10
`define SLOT32 6'h20
`define DLEN24 6'h18
`define WORD_BITS 6'h20
// Master clock half periods per serial clock half period minus one;
// with 2 slots per frame this keeps the master clock at 256 x fs
`define MCK_HALF16 3'h7
`define MCK_HALF32 3'h3
// Transmit queue shape
`define FIFO_W 32
`define FIFO_DEPTH 32
`endif

/* src/ssp_pkg.sv */
// Types of the synchronous serial port.
// Imported whole by the design file.
package ssp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN = 2'h2
  } eng_state_t;
  typedef enum logic [1:0] {
    STD_PHIL = 2'h0,
    STD_MSB = 2'h1,
    STD_LSB = 2'h2,
    STD_PCM = 2'h3
  } std_t;
endpackage

/* src/synchronous_serial_port.sv */
// Synchronous serial port: serial peripheral and audio serial modes
// sharing one shift engine, with a 32-word transmit queue.
// Assumes one 10 MHz clock, a simple strobe register port and pins
// that arrive asynchronously and are resolved by the pad ring.
`timescale 1ns/1ps
`include "ssp_params.svh"

module word_fifo #(
  parameter int W = `FIFO_W,
  parameter int D = `FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t q, d;
  logic push, pop;

  // Honest flags straight from the occupancy count
  assign in_ready = q.cnt != (AW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update; depth is a power of two so pointers wrap
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module synchronous_serial_port
  import ssp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic ws_i,
  output logic ws_o,
  output logic ws_oe_n,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_n,
  output logic mck_o
);
  typedef struct packed {
    eng_state_t st;
    logic [31:0] ctrl;
    logic [7:0] div;
    logic [31:0] rdata;
    logic [7:0] pre;
    logic [2:0] msub;
    logic sck;
    logic ws;
    logic mck;
    logic dout;
    logic sck_oe_n;
    logic ws_oe_n;
    logic dout_oe_n;
    logic [31:0] txs;
    logic [31:0] rxs;
    logic [31:0] rxw;
    logic rx_full;
    logic rx_chan;
    logic ovr;
    logic drop;
    logic done;
    logic [5:0] bitc;
    logic chan;
    logic ws_prev;
    logic [2:0] sck_s;
    logic [2:0] ws_s;
    logic [1:0] din_s;
  } st_t;

  localparam st_t RST_ST = '{
    st: ST_IDLE,
    ctrl: `CTRL_RST,
    div: `DIV_RST,
    ws: 1'b1,
    sck_oe_n: 1'b1,
    ws_oe_n: 1'b1,
    dout_oe_n: 1'b1,
    default: '0
  };

  st_t q, d;
  logic en, mst, aud, txen, rxen, ch32, mcken, tx_act, rx_act;
  std_t std;
  logic [3:0] flen;
  logic [5:0] slot, nbits, off, eb;
  logic [7:0] lim;
  logic tick, sck_tick, rise, fall, start, reload;
  logic ws_now, ws_chg, nss_low;
  logic fifo_in_ready, fifo_out_valid, pop;
  logic [31:0] fifo_out, tx_word;

  // Sample bits per audio data length code; short slots force 16
  function automatic logic [5:0] dbits(input logic [1:0] code,
                                       input logic wide);
    if (!wide || code == 2'h0) begin
      dbits = `SLOT16;
    end else if (code == 2'h1) begin
      dbits = `DLEN24;
    end else begin
      dbits = `SLOT32;
    end
  endfunction

  // Word select level for a bit; left channel is chan 0
  function automatic logic ws_level(input std_t s, input logic c,
                                    input logic first,
                                    input logic last);
    case (s)
      STD_PHIL: ws_level = last ? ~c : c;
      STD_PCM: ws_level = !c && first;
      default: ws_level = ~c;
    endcase
  endfunction

  // Decoded register offsets
  function automatic logic mapped(input logic [3:0] a);
    mapped = a == `A_CTRL || a == `A_DIV || a == `A_DATA ||
             a == `A_STAT;
  endfunction

  // Control fields
  assign en = q.ctrl[`F_EN];
  assign mst = q.ctrl[`F_MST];
  assign aud = q.ctrl[`F_AUD];
  assign txen = q.ctrl[`F_TXEN];
  assign rxen = q.ctrl[`F_RXEN];
  assign ch32 = q.ctrl[`F_CH32];
  assign mcken = q.ctrl[`F_MCKEN];
  assign std = std_t'(q.ctrl[`F_STD]);

  assign tx_act = txen;
  assign rx_act = aud ? !txen : rxen;

  assign flen = (q.ctrl[`F_FLEN] < `FLEN_MIN) ? `FLEN_MIN
                                              : q.ctrl[`F_FLEN];
  assign slot = aud ? (ch32 ? `SLOT32 : `SLOT16)
                    : {2'h0, flen} + 6'h01;
  assign nbits = aud ? dbits(q.ctrl[`F_DLEN], ch32) : slot;
  assign off = (aud && std == STD_LSB) ? slot - nbits : '0;

  // divider limit: power of two or linear
  assign lim = aud ? ((q.div == '0) ? '0 : q.div - 8'h01)
                   : (8'h01 << q.ctrl[`F_BR]) - 8'h01;
  assign tick = q.pre >= lim;
  assign sck_tick = tick &&
    (!aud || q.msub == (ch32 ? `MCK_HALF32 : `MCK_HALF16));

  // Serial clock edges, own in master mode, synchronised in slave
  assign rise = q.st == ST_RUN && (mst ? sck_tick && !q.sck
                                       : q.sck_s[1] && !q.sck_s[2]);
  assign fall = q.st == ST_RUN && (mst ? sck_tick && q.sck
                                       : !q.sck_s[1] && q.sck_s[2]);

  // slave framing follows the far master
  assign ws_now = q.ws_s[1];
  assign nss_low = !ws_now;
  assign ws_chg = aud && !mst && rise &&
    ((std == STD_PCM) ? ws_now && !q.ws_prev : ws_now != q.ws_prev);
  assign eb = !ws_chg ? q.bitc
                      : ((std == STD_PHIL) ? slot - 6'h01 : '0);

  assign start = q.st == ST_IDLE && en &&
    (mst ? (aud || (txen ? fifo_out_valid : rxen))
         : (aud || nss_low));
  assign reload = rise && eb == slot - 6'h01 && (aud || !mst);
  assign pop = tx_act && fifo_out_valid && (start || reload);
  // Queue underrun sends zeros rather than stalling the frame
  assign tx_word = (tx_act && fifo_out_valid)
                   ? fifo_out << (`WORD_BITS - nbits) : '0;

  // Transmit queue; bus writes beyond its depth are dropped
  word_fifo #(
    .W(`FIFO_W),
    .D(`FIFO_DEPTH)
  ) u_txq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(wr && addr == `A_DATA),
    .in_data(wdata),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out),
    .out_ready(pop)
  );

  // Next state: bus, divider, pins and shift engine
  always_comb begin
    d = q;
    // Two flops before any logic looks at a pin
    d.sck_s = {q.sck_s[1:0], sck_i};
    d.ws_s = {q.ws_s[1:0], ws_i};
    d.din_s = {q.din_s[0], din_i};
    // Register writes; flag clears come first so sets win below
    if (wr) begin
      case (addr)
        `A_CTRL: d.ctrl = wdata;
        `A_DIV: d.div = wdata[7:0];
        `A_DATA: d.drop = q.drop || !fifo_in_ready;
        `A_STAT: begin
          if (wdata[`S_OVR]) d.ovr = 1'b0;
          if (wdata[`S_DROP]) d.drop = 1'b0;
        end
        default: ;
      endcase
    end
    // Read data stand only in the cycle after the strobe
    d.rdata = '0;
    if (rd) begin
      case (addr)
        `A_CTRL: d.rdata = q.ctrl;
        `A_DIV: d.rdata = {24'h00_0000, q.div};
        `A_DATA: begin
          d.rdata = q.rxw;
          d.rx_full = 1'b0;
        end
        `A_STAT: begin
          d.rdata[`S_BUSY] = q.st == ST_RUN;
          d.rdata[`S_TXFULL] = !fifo_in_ready;
          d.rdata[`S_TXEMPTY] = !fifo_out_valid;
          d.rdata[`S_RXFULL] = q.rx_full;
          d.rdata[`S_OVR] = q.ovr;
          d.rdata[`S_DROP] = q.drop;
          d.rdata[`S_CHAN] = q.rx_chan;
        end
        default: d.rdata = '0;
      endcase
    end
    // prescaler; master clock toggles per tick
    if (en && mst) begin
      d.pre = tick ? '0 : q.pre + 8'h01;
      if (tick && aud) begin
        d.msub = sck_tick ? '0 : q.msub + 3'h1;
        d.mck = ~q.mck;
      end
    end else begin
      d.pre = '0;
      d.msub = '0;
    end
    if (!(en && mst && aud && mcken)) begin
      d.mck = 1'b0;
    end
    // slave leaves clock and framing to the far master
    d.sck_oe_n = !(en && mst);
    d.ws_oe_n = !(en && mst);
    d.dout_oe_n = !(en && tx_act && (mst || aud || nss_low));
    // Shift engine
    case (q.st)
      ST_IDLE: begin
        d.sck = 1'b0;
        d.ws = !aud;
        d.done = 1'b0;
        if (start) begin
          d.st = ST_RUN;
          d.bitc = '0;
          d.chan = 1'b0;
          d.rxs = '0;
          d.txs = tx_word;
          d.ws_prev = ws_now;
        end
      end
      ST_RUN: begin
        if (!en || (!mst && !aud && !nss_low)) begin
          d.st = ST_IDLE;
        end
        if (mst && sck_tick) begin
          d.sck = ~q.sck;
        end
        if (rise) begin
          d.ws_prev = ws_now;
          // only data bits of the slot are kept
          if (rx_act && eb >= off && eb < off + nbits) begin
            d.rxs = {q.rxs[30:0], q.din_s[1]};
          end
          // slot ends after its last bit
          if (eb == slot - 6'h01) begin
            d.bitc = '0;
            d.chan = ~q.chan;
            if (reload) begin
              d.txs = tx_word;
            end
            if (rx_act) begin
              if (d.rx_full) d.ovr = 1'b1;
              d.rxw = d.rxs;
              d.rx_full = 1'b1;
              d.rx_chan = q.chan;
              d.rxs = '0;
            end
            d.done = mst && !aud;
          end else begin
            d.bitc = eb + 6'h01;
          end
          // slave realigns channel to word select
          if (ws_chg) begin
            d.chan = (std == STD_PHIL) ? ws_now
                   : ((std == STD_PCM) ? 1'b0 : ~ws_now);
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // End of a master frame releases the select line
    if (fall && q.done) begin
      d.st = ST_IDLE;
      d.done = 1'b0;
      d.ws = 1'b1;
    end else if (start || fall) begin
      // Next bit goes out on the falling edge, MSB first
      if (d.bitc >= off && d.bitc < off + nbits) begin
        d.dout = d.txs[31];
        d.txs = {d.txs[30:0], 1'b0};
      end else begin
        d.dout = 1'b0;
      end
      // master drives word select, low as frame select
      d.ws = aud ? ws_level(std, d.chan, d.bitc == '0,
                            d.bitc == slot - 6'h01) : 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= RST_ST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign rdata = q.rdata;
  assign sck_o = q.sck;
  assign sck_oe_n = q.sck_oe_n;
  assign ws_o = q.ws;
  assign ws_oe_n = q.ws_oe_n;
  assign dout_o = q.dout;
  assign dout_oe_n = q.dout_oe_n;
  assign mck_o = q.mck;

  // Checks on the engine, all in the system clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_master_drives_sck: assert property (
    en && mst |=> !sck_oe_n && !ws_oe_n)
    else $error("master does not drive clock and select");

  a_spi_sck_rate: assert property (
    mst && !aud && $stable(q.ctrl) && $changed(sck_o)
      |-> $past(tick))
    else $error("serial clock edge off the divider tick");

  a_frame_bits: assert property (
    !aud |-> slot > {2'h0, `FLEN_MIN} && slot <= `SLOT16 &&
      (q.st != ST_RUN || !$stable(q.ctrl) || q.bitc < slot))
    else $error("frame length outside 4 to 16 bits");

  a_audio_simplex: assert property (
    aud && !txen |=> dout_oe_n)
    else $error("audio receive drives the data pin");

  a_audio_slot: assert property (
    aud |-> (slot == `SLOT16 || slot == `SLOT32) && nbits <= slot)
    else $error("audio slot or sample width illegal");

  a_ws_on_edge: assert property (
    mst && aud && $stable(q.ctrl) && $changed(ws_o)
      |-> $past(fall || start))
    else $error("word select moved off a falling edge");

  a_mck_rate: assert property (
    mcken && $stable(q.ctrl) && $stable(q.div) && $changed(mck_o)
      |-> $past(tick) && $past(q.pre) == $past(lim))
    else $error("master clock off the linear divider");

  a_mck_off: assert property (
    !(mst && aud && mcken) |=> !mck_o)
    else $error("master clock runs while not enabled");

  a_slave_quiet: assert property (
    !mst |=> sck_oe_n ##0 ws_oe_n)
    else $error("slave drives clock or select");

  a_rd_unmapped: assert property (
    rd && !mapped(addr) |=> rdata == '0)
    else $error("unmapped read returned data");
endmodule
